// ### test/test_wbp_watchdog_beeper.sv
// Self-checking bench for the watchdog and tone block.
`timescale 1ns/100ps
`include "wbp_params.svh"
module test_wbp_watchdog_beeper;
  import wbp_pkg::*;
  localparam logic [31:0] ACTL = 32'(`WBP_IDX_CONTROL) << 2;
  localparam logic [31:0] ACNT = 32'(`WBP_IDX_COUNT_VALUE) << 2;
  localparam logic [31:0] AIEN = 32'(`WBP_IDX_IRQ_ENABLE) << 2;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        powerDown = 1'b0;
  logic        hreadyout, hresp, wdtNmi, wdtIrq, toneOut;
  logic [31:0] hrdata, rd, rd2;
  int          failCount = 0, testsRun = 0, halfLen, flips, n;

  // Clock of 4 ns.
  always #2 mclk = ~mclk;

  wbp_watchdog_beeper dut
  (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .powerDown(powerDown),
    .wdtNmi(wdtNmi), .wdtIrq(wdtIrq), .toneOut(toneOut)
  );
  wbp_buzzer_model buzz (.mclk(mclk), .pin(toneOut), .halfLen(halfLen), .flips(flips));

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      failCount++;
    end
  endtask

  // Bounded wait for hready, so a hung slave still ends the run.
  task automatic waitReady();
    int k;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1)
    begin
      failCount++;
      summarize();
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    waitReady();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    waitReady();
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd2);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask

  // Cycles from the run write until a request is seen, bounded by lim.
  task automatic pulseAfter(input int lim);
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while ((wdtNmi | wdtIrq) !== 1'b1 && n < lim);
  endtask

  task automatic resetTest();
    rdc(ACTL, 32'h0);
    rdc(ACNT, 32'h0);
    rdc(AIEN, 32'h0);
    wr(32'h3ec, 32'hff);
    rdc(32'h3ec, 32'h0);
    rdc(AIEN, 32'h0);
  endtask

  task automatic maskTest();
    wr(ACNT, 32'hfe);
    wr(ACTL, 32'h10);
    pulseAfter(600);
    chk(n, 600);
    wr(AIEN, 32'h1);
    wr(ACTL, 32'h10);
    pulseAfter(600);
    chk(n, 3);
    chk(wdtIrq, 1'b1);
    chk(wdtNmi, 1'b0);
    rdc(AIEN, 32'h3);
  endtask

  task automatic clockTest();
    int dv[8] = '{1, 8, 16, 32, 128, 512, 2048, 8192};
    wr(ACNT, 32'hff);
    for (int c = 0; c < 8; c++)
    begin
      wr(ACTL, 32'h18 | c);
      pulseAfter(9000);
      chk(n, dv[c] + 1);
      chk(wdtNmi, 1'b1);
    end
    rdc(ACTL, 32'h0f);
  endtask

  task automatic restartTest();
    wr(ACNT, 32'h10);
    wr(ACTL, 32'h1f);
    rdc(ACNT, 32'h10);
    wr(ACTL, 32'h18);
    wr(ACTL, 32'h08);
    xfer(1'b0, ACNT, 32'h0, rd);
    xfer(1'b0, ACNT, 32'h0, rd2);
    chk((rd2 - rd) & 32'hff, 32'h3);
    powerDown <= 1'b1;
    xfer(1'b0, ACNT, 32'h0, rd);
    xfer(1'b0, ACNT, 32'h0, rd2);
    chk(rd2, rd);
    powerDown <= 1'b0;
  endtask

  task automatic toneTest();
    int td[4] = '{6000, 3000, 1600, 900};
    int f;
    int k;
    for (int s = 0; s < 4; s++)
    begin
      wr(ACTL, 32'h80 | (s << 5));
      f = flips;
      k = 0;
      while (flips < f + 3 && k < 20000)
      begin
        @(posedge mclk);
        k++;
      end
      chk(halfLen, td[s] / 2);
      wr(ACTL, 32'h0);
      repeat (4) @(posedge mclk);
      chk(toneOut, 1'b0);
      f = flips;
      repeat (1000) @(posedge mclk);
      chk(flips, f);
    end
  endtask

  // Reset for three cycles, then each scenario in turn.
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    resetTest();
    maskTest();
    clockTest();
    restartTest();
    toneTest();
    summarize();
  end
endmodule

// ### test/wbp_buzzer_model.sv
// Buzzer on the shared pin: times each level of the tone.
`timescale 1ns/100ps
module wbp_buzzer_model
(
  // Clock.
  input wire logic mclk,
  // Pin, driven once the latch is 1 and the pin is an output.
  input wire logic pin,
  // Last level length in cycles, and count of level changes.
  output int       halfLen,
  output int       flips
);
  int   run = 0;
  logic last = 1'b0;

  // Only a change moves the diaphragm; a steady level is silence.
  always @(posedge mclk)
  begin
    run++;
    if (pin !== last)
    begin
      halfLen = run;
      flips++;
      run = 0;
      last = pin;
    end
  end
endmodule

// ### test/wbp_watchdog_beeper_chk.sv
// Port checks for the watchdog and tone block.
`timescale 1ns/100ps
module wbp_watchdog_beeper_chk
(
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        rst,
  // Bus.
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Watchdog.
  input wire logic        powerDown,
  input wire logic        wdtNmi,
  input wire logic        wdtIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // A transfer counts only when selected with the bus ready.
  logic taken;
  assign taken = hsel && hready && htrans[1];

  a_resp_okay: assert property (hresp == 1'b0) else $error("response not OKAY");
  a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_fast: assert property (taken && hwrite |=> hreadyout) else $error("write stalled");
  a_wait_once: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
  a_rdata_high: assert property (hreadyout |-> hrdata[31:8] == 24'h000000) else $error("upper read bits set");
  a_nmi_pulse: assert property (wdtNmi |=> !wdtNmi) else $error("nmi too long");
  a_irq_pulse: assert property (wdtIrq |=> !wdtIrq) else $error("irq too long");
  a_one_route: assert property (!(wdtNmi && wdtIrq)) else $error("both requests");
  a_frozen_quiet: assert property ($past(powerDown) |-> !wdtNmi && !wdtIrq) else $error("frozen overflow");
endmodule

bind wbp_watchdog_beeper wbp_watchdog_beeper_chk chk
(
  .mclk(mclk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .powerDown(powerDown), .wdtNmi(wdtNmi), .wdtIrq(wdtIrq)
);

// ### verilog/wbp_params.svh
// Constants for the watchdog and tone generator: offsets, fields, reset values and counts.
// How it works
// - Setting the run bit starts the 8-bit counter at the selected counting rate.
// - Every start loads the counter from the stored watchdog start value.
// - Counter overflow raises a watchdog interrupt request.
// - Control bit 3 routes overflow to the non-maskable or maskable request.
// - Maskable request is suppressed while the watchdog interrupt enable bit is clear.
// - Writing 1 to run bit while running reloads the counter and keeps counting.
// - Once started, no software write stops the watchdog.
// - Counting continues in idle mode and freezes during power-down.
// - Clock select codes 0..7 divide by 1, 8, 16, 32, 128, 512, 2048, 8192.
// - Tone select codes 0..3 divide the clock by 6000, 3000, 1600, 900.
// - Tone output is a square wave at the selected divided frequency.
`ifndef WBP_PARAMS_SVH
`define WBP_PARAMS_SVH

// Register indexes; the byte address is four times the index.
`define WBP_IDX_CONTROL      8'hf8
`define WBP_IDX_COUNT_VALUE  8'hf9
`define WBP_IDX_IRQ_ENABLE   8'hfa

// Control register field positions.
`define WBP_CTL_TONE_RUN     7
`define WBP_CTL_TONE_SEL_HI  6
`define WBP_CTL_TONE_SEL_LO  5
`define WBP_CTL_WDT_RUN      4
`define WBP_CTL_IRQ_TYPE     3
`define WBP_CTL_CLK_SEL_HI   2
`define WBP_CTL_CLK_SEL_LO   0

// Interrupt enable register field positions.
`define WBP_IEN_WDT_ENABLE   0
`define WBP_IEN_RUN_FLAG     1

// Reset values.
`define WBP_RST_CONTROL      8'h00
`define WBP_RST_COUNT_VALUE  8'h00
`define WBP_RST_IRQ_ENABLE   1'b0

// Tone dividers of the clock, and the half periods they give.
`define WBP_TONE_DIV0        6000
`define WBP_TONE_DIV1        3000
`define WBP_TONE_DIV2        1600
`define WBP_TONE_DIV3        900
`define WBP_TONE_HALF0       13'(`WBP_TONE_DIV0 / 2)
`define WBP_TONE_HALF1       13'(`WBP_TONE_DIV1 / 2)
`define WBP_TONE_HALF2       13'(`WBP_TONE_DIV2 / 2)
`define WBP_TONE_HALF3       13'(`WBP_TONE_DIV3 / 2)

`endif

// ### verilog/wbp_pkg.sv
// Types shared by the watchdog and tone generator modules.
package wbp_pkg;

  // Watchdog run state.
  typedef enum logic { WBP_WD_STOPPED, WBP_WD_COUNTING } wbp_wd_state_t;

  // Tone divider selection code.
  typedef logic [1:0] wbp_tone_sel_t;

  // Watchdog clock select code.
  typedef logic [2:0] wbp_clk_sel_t;

endpackage

// ### verilog/wbp_tone_gen.sv
// Square-wave tone generator dividing the system clock.
`timescale 1ns/100ps
`include "wbp_params.svh"
module wbp_tone_gen
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Settings in, tone out.
  wbp_tone_if.gen  tone
);
  import wbp_pkg::*;

  logic [12:0] halfCount;
  logic [12:0] next_halfCount;
  logic        level;
  logic        next_level;
  logic [12:0] halfPeriod;

  // Half period in clock cycles for the selected tone.
  always_comb
  begin
    case (tone.toneSelect)
      2'h0:    halfPeriod = `WBP_TONE_HALF0;
      2'h1:    halfPeriod = `WBP_TONE_HALF1;
      2'h2:    halfPeriod = `WBP_TONE_HALF2;
      default: halfPeriod = `WBP_TONE_HALF3;
    endcase
  end

  // The level toggles every half period, giving a 50 percent square wave.
  // A change of tone takes effect at once; the comparison uses >= so a shorter
  // period never leaves the counter stranded above its new limit.
  always_comb
  begin
    next_halfCount = halfCount;
    next_level     = level;
    if (!tone.toneEnable)
    begin
      next_halfCount = 13'h0000;
      next_level     = 1'b0;
    end
    else if (halfCount >= halfPeriod - 13'h0001)
    begin
      next_halfCount = 13'h0000;
      next_level     = ~level;
    end
    else
    begin
      next_halfCount = halfCount + 13'h0001;
    end
  end

  // Tone registers.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      halfCount <= 13'h0000;
      level     <= 1'b0;
    end
    else
    begin
      halfCount <= next_halfCount;
      level     <= next_level;
    end
  end

  assign tone.toneLevel = level;
endmodule

// ### verilog/wbp_tone_if.sv
// Interface joining the register block to the tone generator.
`timescale 1ns/100ps
interface wbp_tone_if;
  import wbp_pkg::*;

  logic          toneEnable;
  wbp_tone_sel_t toneSelect;
  logic          toneLevel;

  // Register side drives the settings and reads the tone.
  modport ctl (output toneEnable, output toneSelect, input toneLevel);

  // Generator side.
  modport gen (input toneEnable, input toneSelect, output toneLevel);
endinterface

// ### verilog/wbp_watchdog_beeper.sv
// Watchdog counter and tone generator with an AHB-Lite register slave.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
`include "wbp_params.svh"
module wbp_watchdog_beeper
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Power state from the power controller, same clock.
  input  wire logic        powerDown,
  // Watchdog interrupt requests.
  output logic             wdtNmi,
  output logic             wdtIrq,
  // Tone towards the shared port pin.
  output logic             toneOut
);
  import wbp_pkg::*;

  // Register map, one aligned word each, data in bits 7 to 0:
  //   control     - tone run, tone select, run bit, interrupt type, clock select.
  //   count value - a write sets the start value; a read returns the live counter.
  //   irq enable  - bit 0 enables the maskable request; bit 1 shows that the watchdog runs.
  // The run bit is an event, not storage, so it always reads 0 and a read-modify-write
  // of the control byte never restarts the watchdog by accident.

  // Bus phase tracking.
  logic       wrPend;
  logic       next_wrPend;
  logic [7:0] wrIdx;
  logic [7:0] next_wrIdx;
  logic       rdWait;
  logic       next_rdWait;
  logic [7:0] rdIdx;
  logic [7:0] next_rdIdx;
  logic       next_hreadyout;
  logic       next_hresp;
  logic [31:0] next_hrdata;
  logic       addrTaken;
  logic       idxValid;
  logic [7:0] addrIdx;

  // Register contents.
  logic [7:0] control;
  logic [7:0] next_control;
  logic [7:0] startValue;
  logic [7:0] next_startValue;
  logic       irqEnable;
  logic       next_irqEnable;
  logic       startReq;

  // Watchdog state.
  wbp_wd_state_t wdState;
  wbp_wd_state_t next_wdState;
  logic [7:0]  count;
  logic [7:0]  next_count;
  logic [12:0] prescale;
  logic [12:0] next_prescale;
  logic [12:0] tickMask;
  logic        tick;
  logic        overflow;
  logic        next_wdtNmi;
  logic        next_wdtIrq;
  logic        next_toneOut;

  // Tone generator link.
  wbp_tone_if toneLink ();

  // Word index of the address phase; only addresses below the register window
  // top decode, anything else is unmapped and answers OKAY with zero data.
  assign addrIdx   = haddr[9:2];
  assign idxValid  = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign addrTaken = hsel && hready && htrans[1];

  // Bus tracking: writes finish with no wait state, reads add one wait state
  // so that the data always reflects a write whose data phase just ended.
  // No address phase is taken during the wait, since hready is then low.
  always_comb
  begin
    next_wrPend    = 1'b0;
    next_wrIdx     = wrIdx;
    next_rdWait    = 1'b0;
    next_rdIdx     = rdIdx;
    next_hreadyout = 1'b1;
    next_hrdata    = hrdata;
    if (rdWait)
    begin
      next_hreadyout = 1'b1;
      next_hrdata    = 32'h00000000;
      case (rdIdx)
        `WBP_IDX_CONTROL:
          next_hrdata[7:0] = control;
        `WBP_IDX_COUNT_VALUE:
          next_hrdata[7:0] = count;
        `WBP_IDX_IRQ_ENABLE:
        begin
          next_hrdata[`WBP_IEN_WDT_ENABLE] = irqEnable;
          next_hrdata[`WBP_IEN_RUN_FLAG]   = (wdState == WBP_WD_COUNTING);
        end
        default:
          next_hrdata = 32'h00000000;
      endcase
    end
    else if (addrTaken)
    begin
      if (hwrite)
      begin
        next_wrPend = 1'b1;
        next_wrIdx  = idxValid ? addrIdx : 8'h00;
      end
      else
      begin
        next_rdWait    = 1'b1;
        next_rdIdx     = idxValid ? addrIdx : 8'h00;
        next_hreadyout = 1'b0;
      end
    end
  end

  // Bus registers. The read data keep their value until the next read
  // completes.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wrPend    <= 1'b0;
      wrIdx     <= 8'h00;
      rdWait    <= 1'b0;
      rdIdx     <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
    end
    else
    begin
      wrPend    <= next_wrPend;
      wrIdx     <= next_wrIdx;
      rdWait    <= next_rdWait;
      rdIdx     <= next_rdIdx;
      hreadyout <= next_hreadyout;
      hrdata    <= next_hrdata;
    end
  end

  // The slave never signals an error. The response still leaves through a flop
  // so that every bus output is registered and free of glitches.
  assign next_hresp = 1'b0;

  // Response register.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= next_hresp;
    end
  end

  // A write of 1 to the run bit asks for a start or a restart.
  // Only the data phase decides; an address phase alone never restarts.
  assign startReq = wrPend && (wrIdx == `WBP_IDX_CONTROL) && hwdata[`WBP_CTL_WDT_RUN];

  // Register writes happen in the data phase. The run bit is never stored, so
  // it always reads 0 and a start is a single event per write.
  always_comb
  begin
    next_control    = control;
    next_startValue = startValue;
    next_irqEnable  = irqEnable;
    if (wrPend)
    begin
      case (wrIdx)
        `WBP_IDX_CONTROL:
        begin
          next_control                  = hwdata[7:0];
          next_control[`WBP_CTL_WDT_RUN] = 1'b0;
        end
        `WBP_IDX_COUNT_VALUE:
          next_startValue = hwdata[7:0];
        `WBP_IDX_IRQ_ENABLE:
          next_irqEnable = hwdata[`WBP_IEN_WDT_ENABLE];
        default:
          next_control = control;
      endcase
    end
  end

  // Register storage. The values survive power-down; only reset clears
  // them.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      control    <= `WBP_RST_CONTROL;
      startValue <= `WBP_RST_COUNT_VALUE;
      irqEnable  <= `WBP_RST_IRQ_ENABLE;
    end
    else
    begin
      control    <= next_control;
      startValue <= next_startValue;
      irqEnable  <= next_irqEnable;
    end
  end

  // Divider mask: a tick comes when the masked prescaler bits are all ones,
  // so code 0 ticks every cycle and code 7 once in 8192 cycles.
  // Sharing one prescaler saves a counter per rate; the price is that a change
  // of clock select without a restart may bring the next tick early.
  always_comb
  begin
    case (wbp_clk_sel_t'(control[`WBP_CTL_CLK_SEL_HI:`WBP_CTL_CLK_SEL_LO]))
      3'h0:    tickMask = 13'h0000;
      3'h1:    tickMask = 13'h0007;
      3'h2:    tickMask = 13'h000f;
      3'h3:    tickMask = 13'h001f;
      3'h4:    tickMask = 13'h007f;
      3'h5:    tickMask = 13'h01ff;
      3'h6:    tickMask = 13'h07ff;
      default: tickMask = 13'h1fff;
    endcase
  end

  assign tick     = ((prescale & tickMask) == tickMask);

  // A restart in the very cycle of the wrap wins: the counter is reloaded instead
  // of wrapping, so no request is raised for a program that kicked in time.
  assign overflow = (wdState == WBP_WD_COUNTING) && !powerDown && !startReq && tick && (count == 8'hff);

  // Watchdog counting. There is no path from counting back to stopped other
  // than reset, which is what keeps a runaway program from disabling it.
  always_comb
  begin
    next_wdState  = wdState;
    next_count    = count;
    next_prescale = prescale;
    next_wdtNmi   = 1'b0;
    next_wdtIrq   = 1'b0;
    if (startReq)
    begin
      next_wdState  = WBP_WD_COUNTING;
      next_count    = startValue;
      next_prescale = 13'h0000;
    end
    else
    begin
      case (wdState)
        WBP_WD_COUNTING:
        begin
          // Power-down freezes everything; idle is not seen here and counts on.
          if (!powerDown)
          begin
            next_prescale = prescale + 13'h0001;
            if (tick)
            begin
              next_count = count + 8'h01;
            end
          end
        end
        default:
          next_wdState = wdState;
      endcase
    end
    // The type bit steers the overflow; the enable gates only the maskable path.
    if (overflow)
    begin
      if (control[`WBP_CTL_IRQ_TYPE])
      begin
        next_wdtNmi = 1'b1;
      end
      else
      begin
        next_wdtIrq = irqEnable;
      end
    end
  end

  // Watchdog registers. The request flops make both pulses exactly one
  // cycle long, whatever the counting rate.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wdState  <= WBP_WD_STOPPED;
      count    <= 8'h00;
      prescale <= 13'h0000;
      wdtNmi   <= 1'b0;
      wdtIrq   <= 1'b0;
    end
    else
    begin
      wdState  <= next_wdState;
      count    <= next_count;
      prescale <= next_prescale;
      wdtNmi   <= next_wdtNmi;
      wdtIrq   <= next_wdtIrq;
    end
  end

  // Tone settings come straight from the control register.
  // A new tone select takes effect at once, without waiting for a period to end.
  assign toneLink.toneEnable = control[`WBP_CTL_TONE_RUN];
  assign toneLink.toneSelect = control[`WBP_CTL_TONE_SEL_HI:`WBP_CTL_TONE_SEL_LO];

  // Tone generator.
  wbp_tone_gen u_tone
  (
    .mclk (mclk),
    .rst  (rst),
    .tone (toneLink.gen)
  );

  // The port pin latch and direction live outside; software must set the latch
  // to 1 and the pin to output before the tone can reach the transducer.
  // A tone that runs while the pin is still an input is simply not heard.
  assign next_toneOut = toneLink.toneLevel;

  // Output flop for the tone; it adds one cycle of delay, which is harmless
  // against periods of hundreds of cycles.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      toneOut <= 1'b0;
    end
    else
    begin
      toneOut <= next_toneOut;
    end
  end

  // The transfer size is not checked: every register is one word.
  // A narrow write therefore still updates the whole register byte.
  logic unusedSize;
  assign unusedSize = ^hsize;
endmodule
